/* core/buck_pkg.sv */
// Shared constants and types for the buck regulator control block
package buck_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CORE_CTRL_ADDR    = 8'h39;
  localparam logic [7:0] COMMS_CTRL_ADDR   = 8'h3C;
  localparam logic [7:0] CORE_CUR_LO_ADDR  = 8'h50;
  localparam logic [7:0] CORE_CUR_HI_ADDR  = 8'h51;
  localparam logic [7:0] COMMS_CUR_LO_ADDR = 8'h52;
  localparam logic [7:0] COMMS_CUR_HI_ADDR = 8'h53;
  localparam logic [7:0] FAULT_STAT_ADDR   = 8'h54;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CORE_CTRL_RST  = 8'h07;
  localparam logic [7:0] COMMS_CTRL_RST = 8'h24;

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int STATE_LSB = 0;
  localparam int EXIT_LSB  = 3;
  localparam int VSEL_LSB  = 6;
  localparam int FIELD_W   = 3;
  localparam int VSEL_W    = 2;

  // State codes; bit 2 clear marks a reserved or do-not-copy code
  localparam logic [2:0] STATE_OFF = 3'h4;
  localparam logic [2:0] STATE_PFM = 3'h5;
  localparam logic [2:0] STATE_APS = 3'h6;
  localparam logic [2:0] STATE_PWM = 3'h7;

  // Voltage select codes
  localparam logic [1:0] VSEL_LOW  = 2'h0;
  localparam logic [1:0] VSEL_HIGH = 2'h1;

  // Synchroniser depth and status bit positions
  localparam int SYNC_STAGES     = 2;
  localparam int FAULT_CORE_BIT  = 0;
  localparam int FAULT_COMMS_BIT = 1;

  // Operating mode as driven to the power stage
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_PFM = 2'b01,
    MODE_APS = 2'b10,
    MODE_PWM = 2'b11
  } buck_mode_t;

endpackage

/* core/buck_chan_if.sv */
// Carrier between the top and one regulator channel
`timescale 1ns/1ps
interface buck_chan_if #(parameter int ADC_W = 10);
  logic                    ctrl_wr;
  logic [7:0]              ctrl_wdata;
  logic                    exit_pulse;
  logic                    oc_sync;
  logic                    adc_valid;
  logic [ADC_W-1:0]        adc_data;
  logic [7:0]              ctrl_q;
  buck_pkg::buck_mode_t    mode;
  logic                    discharge;
  logic                    fault;
  logic [ADC_W-1:0]        current_q;

  modport top  (output ctrl_wr, ctrl_wdata, exit_pulse, oc_sync, adc_valid, adc_data,
                input ctrl_q, mode, discharge, fault, current_q);
  modport chan (input ctrl_wr, ctrl_wdata, exit_pulse, oc_sync, adc_valid, adc_data,
                output ctrl_q, mode, discharge, fault, current_q);
endinterface

/* core/buck_channel.sv */
// One buck regulator channel: control register, mode, discharge, fault, current
`timescale 1ns/1ps
module buck_channel #(
  parameter logic [7:0] CTRL_RST = buck_pkg::CORE_CTRL_RST,
  parameter int         ADC_W    = 10
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Channel carrier
  buck_chan_if.chan ch
);

  logic [7:0]       ctrl_r,    ctrl_nxt;
  logic             dsch_r,    dsch_nxt;
  logic             fault_r,   fault_nxt;
  logic [ADC_W-1:0] current_r, current_nxt;

  // Field tops, declared before the next-state logic that reads them
  localparam int STATE_MSB = buck_pkg::STATE_LSB + buck_pkg::FIELD_W - 1;
  localparam int EXIT_MSB  = buck_pkg::EXIT_LSB + buck_pkg::FIELD_W - 1;

  // A zero-width result register cannot be built
  if (ADC_W < 1 || ADC_W > 16) begin : g_bad_adc_w
    $error("ADC_W must lie between 1 and 16");
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Exit copy is applied after a same-cycle write so the pin has the last word
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ch.ctrl_wr) begin
      ctrl_nxt = ch.ctrl_wdata;                                  // R6
      if (!ch.ctrl_wdata[STATE_MSB]) begin
        ctrl_nxt[2:0] = ctrl_r[2:0];                             // R12
      end
    end
    if (ch.exit_pulse && ctrl_nxt[EXIT_MSB]) begin
      ctrl_nxt[2:0] = ctrl_nxt[5:3];                             // R2
    end
    dsch_nxt    = (ctrl_nxt[2:0] == buck_pkg::STATE_OFF);        // R8
    fault_nxt   = ch.oc_sync;                                    // R7
    current_nxt = ch.adc_valid ? ch.adc_data : current_r;        // R9
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r    <= CTRL_RST;                                     // R5
      dsch_r    <= (CTRL_RST[2:0] == buck_pkg::STATE_OFF);
      fault_r   <= 1'b0;
      current_r <= '0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      dsch_r    <= dsch_nxt;
      fault_r   <= fault_nxt;
      current_r <= current_nxt;
    end
  end

  // Codes 4..7 differ only in the low two bits, which map straight onto the mode
  assign ch.ctrl_q    = ctrl_r;
  assign ch.mode      = buck_pkg::buck_mode_t'(ctrl_r[1:0]);     // R1
  assign ch.discharge = dsch_r;
  assign ch.fault     = fault_r;
  assign ch.current_q = current_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reserved_hold: assert property (@(posedge clk_sys) disable iff (rst) // R12
    ch.ctrl_wr && !ch.ctrl_wdata[2] && !ch.exit_pulse |=> ctrl_r[2:0] == $past(ctrl_r[2:0]))
    else $error("Reserved state code changed the regulator state");
  a_exit_copy: assert property (@(posedge clk_sys) disable iff (rst) // R2
    ch.exit_pulse && !ch.ctrl_wr && ctrl_r[5] |=> ctrl_r[2:0] == $past(ctrl_r[5:3]))
    else $error("Standby exit did not load the exit state");
  a_discharge_off: assert property (@(posedge clk_sys) disable iff (rst) // R8
    ch.discharge == (ch.mode == buck_pkg::MODE_OFF))
    else $error("Discharge path does not follow the off state");
  a_state_legal: assert property (@(posedge clk_sys) disable iff (rst) // R1
    ctrl_r[2] == 1'b1)
    else $error("Operating state holds a reserved code");

endmodule // buck_channel

/* core/buck_regulator_control.sv */
// Control and fault reporting for the core pre-regulator and comms core buck
`timescale 1ns/1ps

// Operation
// R1 - State field codes: 4 off, 5/6/7 modes
// R2 - Exit pin loads exit field into state
// R3 - Host programs exit field after power-up
// R4 - Bits 7:6 select core level 1.5/1.6V
// R5 - Core control at 0x39, resets 0x07
// R6 - Host-written comms mode is applied
// R7 - Over-current limits, faults, raises shared interrupt
// R8 - Discharge output whenever regulator shut down
// R9 - ADC output current kept readable
// R10 - Comms: fixed level or Mini-SPI adjustable
// R11 - Comms select 0 fixed, 1 Mini-SPI
// R12 - Reserved state write keeps current state
module buck_regulator_control #(
  parameter int ADC_W = 10
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // Register port from the SPI decoder
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  // Pins from outside the clock domain
  input  wire logic                 standby_exit_pin,
  input  wire logic                 core_oc_pin,
  input  wire logic                 comms_oc_pin,
  // ADC results, same clock
  input  wire logic                 adc_valid,
  input  wire logic                 adc_sel_comms,
  input  wire logic [ADC_W-1:0]     adc_data,
  // Core pre-regulator power stage
  output buck_pkg::buck_mode_t      core_buck_mode,
  output logic                      core_buck_discharge,
  output logic                      core_buck_current_limit,
  output logic                      core_buck_level_high,
  output logic                      core_buck_fault,
  // Comms core regulator power stage
  output buck_pkg::buck_mode_t      comms_buck_mode,
  output logic                      comms_buck_discharge,
  output logic                      comms_buck_current_limit,
  output logic                      comms_buck_mini_spi_ctrl,
  output logic                      comms_core_fault,
  // Shared fault interrupt
  output logic                      regulator_fault_interrupt
);

  // Refused at elaboration: the readback splits results over two bytes
  if (ADC_W < 1 || ADC_W > 16) begin : g_bad_adc_w
    $error("ADC_W must lie between 1 and 16");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 3;
  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] sync1_r, sync1_nxt;
  logic [NPIN-1:0] sync2_r, sync2_nxt;
  logic            exit_d_r, exit_d_nxt;
  logic            exit_pulse;

  assign pin_in = {comms_oc_pin, core_oc_pin, standby_exit_pin};

  // Stage one is read only by stage two
  always_comb begin
    sync1_nxt  = pin_in;
    sync2_nxt  = sync1_r;
    exit_d_nxt = sync2_r[0];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_r  <= '0;
      sync2_r  <= '0;
      exit_d_r <= 1'b0;
    end else begin
      sync1_r  <= sync1_nxt;
      sync2_r  <= sync2_nxt;
      exit_d_r <= exit_d_nxt;
    end
  end

  // A held exit pin copies once, on its rising edge
  assign exit_pulse = sync2_r[0] && !exit_d_r;                   // R2

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  buck_chan_if #(.ADC_W(ADC_W)) core_ch ();
  buck_chan_if #(.ADC_W(ADC_W)) comms_ch ();

  // Register writes decode by offset; both channels see the same exit edge
  assign core_ch.ctrl_wr     = reg_wr && (reg_addr == buck_pkg::CORE_CTRL_ADDR);   // R5
  assign core_ch.ctrl_wdata  = reg_wdata;
  assign core_ch.exit_pulse  = exit_pulse;
  assign core_ch.oc_sync     = sync2_r[1];
  assign core_ch.adc_valid   = adc_valid && !adc_sel_comms;
  assign core_ch.adc_data    = adc_data;
  assign comms_ch.ctrl_wr    = reg_wr && (reg_addr == buck_pkg::COMMS_CTRL_ADDR);  // R6
  assign comms_ch.ctrl_wdata = reg_wdata;
  assign comms_ch.exit_pulse = exit_pulse;
  assign comms_ch.oc_sync    = sync2_r[2];
  assign comms_ch.adc_valid  = adc_valid && adc_sel_comms;
  assign comms_ch.adc_data   = adc_data;

  buck_channel #(.CTRL_RST(buck_pkg::CORE_CTRL_RST), .ADC_W(ADC_W)) u_core (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ch      (core_ch.chan)
  );

  buck_channel #(.CTRL_RST(buck_pkg::COMMS_CTRL_RST), .ADC_W(ADC_W)) u_comms (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ch      (comms_ch.chan)
  );

  // ----------------------------------------------------------------
  // Power stage outputs
  // ----------------------------------------------------------------
  // Limit and fault share one flop: the limit is cycle by cycle, not latched
  assign core_buck_mode           = core_ch.mode;                // R1
  assign core_buck_discharge      = core_ch.discharge;           // R8
  assign core_buck_current_limit  = core_ch.fault;               // R7
  assign core_buck_fault          = core_ch.fault;
  assign core_buck_level_high     = (core_ch.ctrl_q[7:6] == buck_pkg::VSEL_HIGH);  // R4
  assign comms_buck_mode          = comms_ch.mode;               // R6
  assign comms_buck_discharge     = comms_ch.discharge;          // R8
  assign comms_buck_current_limit = comms_ch.fault;              // R7
  assign comms_core_fault         = comms_ch.fault;
  // Select 0 holds the fixed level; 1 hands the level to the Mini-SPI link
  assign comms_buck_mini_spi_ctrl = (comms_ch.ctrl_q[7:6] == buck_pkg::VSEL_HIGH); // R10 R11

  // ----------------------------------------------------------------
  // Shared fault interrupt
  // ----------------------------------------------------------------
  logic irq_r, irq_nxt;

  always_comb begin
    irq_nxt = core_ch.fault || comms_ch.fault;                   // R7
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign regulator_fault_interrupt = irq_r;

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  logic [7:0]  rdata_r, rdata_nxt;
  logic [15:0] core_cur16;
  logic [15:0] comms_cur16;

  assign core_cur16  = 16'(core_ch.current_q);
  assign comms_cur16 = 16'(comms_ch.current_q);

  // Unmapped offsets read as zero; data holds until the next read
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      case (reg_addr)
        buck_pkg::CORE_CTRL_ADDR:    rdata_nxt = core_ch.ctrl_q;
        buck_pkg::COMMS_CTRL_ADDR:   rdata_nxt = comms_ch.ctrl_q;
        buck_pkg::CORE_CUR_LO_ADDR:  rdata_nxt = core_cur16[7:0];    // R9
        buck_pkg::CORE_CUR_HI_ADDR:  rdata_nxt = core_cur16[15:8];
        buck_pkg::COMMS_CUR_LO_ADDR: rdata_nxt = comms_cur16[7:0];   // R9
        buck_pkg::COMMS_CUR_HI_ADDR: rdata_nxt = comms_cur16[15:8];
        buck_pkg::FAULT_STAT_ADDR:   rdata_nxt = {6'h00, comms_ch.fault, core_ch.fault};
        default:                     rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ctrl_reset_value: assert property (@(posedge clk_sys) // R5
    $fell(rst) |-> core_ch.ctrl_q == 8'h07)
    else $error("Core control register left reset with a wrong value");
  a_oc_to_irq: assert property (@(posedge clk_sys) disable iff (rst) // R7
    $rose(sync2_r[1]) |=> core_buck_fault ##1 regulator_fault_interrupt)
    else $error("Over-current did not raise the fault interrupt in time");
  a_irq_follows_fault: assert property (@(posedge clk_sys) disable iff (rst) // R7
    regulator_fault_interrupt == $past(core_buck_fault || comms_core_fault))
    else $error("Fault interrupt does not follow the regulator faults");
  a_comms_mode_write: assert property (@(posedge clk_sys) disable iff (rst) // R6
    comms_ch.ctrl_wr && reg_wdata[2] && !exit_pulse
      |=> comms_buck_mode == buck_pkg::buck_mode_t'($past(reg_wdata[1:0])))
    else $error("Written comms mode was not applied");
  a_core_read_back: assert property (@(posedge clk_sys) disable iff (rst) // R5
    reg_rd && reg_addr == 8'h39 |=> reg_rdata == $past(core_ch.ctrl_q))
    else $error("Core control register read back wrong");
  a_current_read: assert property (@(posedge clk_sys) disable iff (rst) // R9
    adc_valid && !adc_sel_comms ##1 reg_rd && reg_addr == 8'h50
      |=> reg_rdata == $past(adc_data[7:0], 2))
    else $error("Core current result not readable");
  a_mini_spi_sel: assert property (@(posedge clk_sys) disable iff (rst) // R11
    comms_buck_mini_spi_ctrl == (comms_ch.ctrl_q[7:6] == 2'b01))
    else $error("Mini-SPI control does not follow the voltage select");

endmodule // buck_regulator_control

/* testbench/host_model.sv */
// Host processor model issuing register writes and reads over the offset port
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic       clk_sys,
  // Register port toward the block
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // One-cycle write strobe, then one edge for the outputs to settle
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d; // Stale data would hide a late capture
    @(posedge clk_sys);
    #1;
  endtask

  // Read data is registered, so it is taken one edge after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(posedge clk_sys);
    #1;
    d = reg_rdata;
  endtask

  // Programs the exit field of the core control right after power-up
  task automatic power_up(input logic [2:0] ex);
    write_reg(buck_pkg::CORE_CTRL_ADDR, {2'b00, ex, 3'h7});
  endtask
endmodule // host_model

/* testbench/tb_buck_regulator_control.sv */
// Self-checking testbench for the buck regulator control block
`timescale 1ns/1ps
module tb_buck_regulator_control;
  logic clk_sys, rst, standby_exit_pin, core_oc_pin, comms_oc_pin;
  logic adc_valid, adc_sel_comms, reg_wr, reg_rd;
  logic [9:0] adc_data;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  buck_pkg::buck_mode_t core_buck_mode, comms_buck_mode;
  logic core_dis, core_lim, core_hi, core_flt, comms_dis, comms_lim, comms_mini, comms_flt, irq;
  int error_cnt = 0;
  int cmp_count = 0;

  // ----------------------------------------------------------------
  // Clock, instances
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  host_model host_u (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  buck_regulator_control #(.ADC_W(10)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .standby_exit_pin(standby_exit_pin),
    .core_oc_pin(core_oc_pin), .comms_oc_pin(comms_oc_pin), .adc_valid(adc_valid),
    .adc_sel_comms(adc_sel_comms), .adc_data(adc_data),
    .core_buck_mode(core_buck_mode), .core_buck_discharge(core_dis),
    .core_buck_current_limit(core_lim), .core_buck_level_high(core_hi),
    .core_buck_fault(core_flt), .comms_buck_mode(comms_buck_mode),
    .comms_buck_discharge(comms_dis), .comms_buck_current_limit(comms_lim),
    .comms_buck_mini_spi_ctrl(comms_mini), .comms_core_fault(comms_flt),
    .regulator_fault_interrupt(irq));

  // ----------------------------------------------------------------
  // Checking and verdict
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Waits edges after a pin change made by non-blocking assignment
  task automatic edges(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    host_u.read_reg(buck_pkg::CORE_CTRL_ADDR, rd);
    chk(rd, 16'h0007);
    chk(core_buck_mode, buck_pkg::MODE_PWM);
    chk(comms_dis, 1'b1);
    host_u.read_reg(8'h7E, rd);
    chk(rd, 16'h0000);
    $display("test reset done");
  endtask

  // Every state code on the comms control, reserved codes keep the state
  task automatic t_states();
    for (int c = 7; c >= 0; c--) begin
      host_u.write_reg(buck_pkg::COMMS_CTRL_ADDR, {5'b0100_0, c[2:0]});
      chk(comms_buck_mode, (c >= 4) ? c[1:0] : 2'h0);
      chk(comms_dis, (c <= 4) ? 1'b1 : 1'b0);
      chk(comms_mini, 1'b1);
    end
    host_u.write_reg(buck_pkg::COMMS_CTRL_ADDR, 8'h06);
    host_u.write_reg(buck_pkg::COMMS_CTRL_ADDR, 8'h01);
    chk(comms_buck_mode, buck_pkg::MODE_APS);
    chk(comms_mini, 1'b0);
    host_u.read_reg(buck_pkg::COMMS_CTRL_ADDR, rd);
    chk(rd, 16'h0006);
    host_u.write_reg(buck_pkg::CORE_CTRL_ADDR, 8'h45);
    chk(core_hi, 1'b1);
    chk(core_buck_mode, buck_pkg::MODE_PFM);
    host_u.write_reg(buck_pkg::CORE_CTRL_ADDR, 8'hC4);
    chk(core_hi, 1'b0);
    chk(core_dis, 1'b1);
    $display("test states done");
  endtask

  // Exit pin copies exit field; a do-not-copy field leaves the state
  task automatic t_exit();
    host_u.power_up(3'h6);
    host_u.write_reg(buck_pkg::COMMS_CTRL_ADDR, 8'h2F);
    @(posedge clk_sys);
    standby_exit_pin <= 1'b1;
    edges(3);
    chk(core_buck_mode, buck_pkg::MODE_APS);
    chk(comms_buck_mode, buck_pkg::MODE_PFM);
    @(posedge clk_sys);
    standby_exit_pin <= 1'b0;
    host_u.write_reg(buck_pkg::CORE_CTRL_ADDR, 8'h27);
    host_u.write_reg(buck_pkg::COMMS_CTRL_ADDR, 8'h07);
    @(posedge clk_sys);
    standby_exit_pin <= 1'b1;
    edges(4);
    chk(comms_buck_mode, buck_pkg::MODE_PWM);
    chk(core_buck_mode, buck_pkg::MODE_OFF);
    chk(core_dis, 1'b1);
    @(posedge clk_sys);
    standby_exit_pin <= 1'b0;
    $display("test exit done");
  endtask

  // Over-current on each channel raises fault, limit, then interrupt
  task automatic t_fault();
    @(posedge clk_sys);
    core_oc_pin <= 1'b1;
    edges(3);
    chk({core_flt, core_lim, irq}, 3'b110);
    edges(1);
    chk(irq, 1'b1);
    @(posedge clk_sys);
    core_oc_pin <= 1'b0;
    comms_oc_pin <= 1'b1;
    edges(4);
    chk({comms_flt, comms_lim, core_flt, irq}, 4'b1101);
    host_u.read_reg(buck_pkg::FAULT_STAT_ADDR, rd);
    chk(rd, 16'h0002);
    @(posedge clk_sys);
    comms_oc_pin <= 1'b0;
    edges(4);
    chk(irq, 1'b0);
    $display("test fault done");
  endtask

  // Current results per channel, low byte and two high bits
  task automatic t_adc();
    @(posedge clk_sys);
    adc_valid     <= 1'b1;
    adc_sel_comms <= 1'b0;
    adc_data      <= 10'h2A5;
    // Read follows the result at once, so the readback path is hit directly
    fork
      host_u.read_reg(buck_pkg::CORE_CUR_LO_ADDR, rd);
      begin
        @(posedge clk_sys);
        adc_sel_comms <= 1'b1;
        adc_data      <= 10'h15A;
        @(posedge clk_sys);
        adc_valid     <= 1'b0;
      end
    join
    chk(rd, 16'h00A5);
    host_u.read_reg(buck_pkg::CORE_CUR_HI_ADDR, rd);
    chk(rd, 16'h0002);
    host_u.read_reg(buck_pkg::COMMS_CUR_LO_ADDR, rd);
    chk(rd, 16'h005A);
    host_u.read_reg(buck_pkg::COMMS_CUR_HI_ADDR, rd);
    chk(rd, 16'h0001);
    $display("test adc done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {standby_exit_pin, core_oc_pin, comms_oc_pin, adc_valid, adc_sel_comms} = 5'h00;
    adc_data = 10'h000;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_states();
    t_exit();
    t_fault();
    t_adc();
    give_verdict();
  end

  // The tests take about a hundred cycles; this bound is far beyond that
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end
endmodule // tb_buck_regulator_control
